// File: logic/mio_pkg.sv
// Shared constants, command encodings and carrier types of the motion I/O port
package mio_pkg;
	// ----------------------------------------------------------------
	// Line counts and widths
	// ----------------------------------------------------------------
	localparam int unsigned BASE_IN_N = 16;
	localparam int unsigned EXT_IN_MAX = 24;
	localparam int unsigned IN_W = BASE_IN_N + EXT_IN_MAX;
	localparam int unsigned BASE_OUT_N = 8;
	localparam int unsigned EXT_OUT_MAX = 24;
	localparam int unsigned OUT_W = BASE_OUT_N + EXT_OUT_MAX;
	localparam int unsigned SHARED_FIRST = 4;
	localparam int unsigned SHARED_LAST = 15;
	localparam int unsigned HALL_W = SHARED_LAST - SHARED_FIRST + 1;
	localparam int unsigned CFG_W = 8;
	localparam int unsigned IDX_W = 6;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int unsigned HALL_SRC_BIT = 3;
	localparam int unsigned EXT_IN_EN_BIT = 0;
	localparam int unsigned EXT_OUT_EN_BIT = 1;
	localparam logic [IN_W-1:0] IN_IDLE = {IN_W{1'b1}};
	localparam logic [HALL_W-1:0] HALL_IDLE = {HALL_W{1'b1}};
	localparam logic [OUT_W-1:0] OUT_RST = {OUT_W{1'b0}};

	// ----------------------------------------------------------------
	// Host commands and carriers
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		MIO_OP_NONE,
		MIO_OP_READ_ALL,
		MIO_OP_READ_ONE,
		MIO_OP_SET_OUT,
		MIO_OP_EXT_SETUP
	} mio_op_e;

	typedef struct packed {
		mio_op_e op;
		logic [OUT_W-1:0] data;
		logic [IDX_W-1:0] idx;
	} mio_cmd_s;

	typedef struct packed {
		logic valid;
		logic [IN_W-1:0] word;
		logic line_val;
	} mio_rsp_s;

	typedef struct packed {
		logic [OUT_W-1:0] o;
		logic [OUT_W-1:0] oe;
	} mio_oc_s;
endpackage : mio_pkg

// File: logic/mio_port.sv
// Motion I/O port: synchronised inputs, hall routing, open-collector outputs, brake
`timescale 1ns/100ps

module mio_port #(
	parameter int unsigned EXT_IN_N = 24,
	parameter int unsigned EXT_OUT_N = 24
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Field side
	input wire logic [mio_pkg::IN_W-1:0] in_pins,
	input wire logic [mio_pkg::HALL_W-1:0] main_hall_pins,
	output mio_pkg::mio_oc_s out_pins,
	output logic brake_o,
	output logic brake_oe,
	// Card side
	input wire logic [mio_pkg::CFG_W-1:0] opt_setup_code,
	input wire logic hall_claim,
	input wire logic brake_engage,
	output logic [mio_pkg::HALL_W-1:0] hall_sig,
	// Host command port
	input mio_pkg::mio_cmd_s cmd,
	output mio_pkg::mio_rsp_s rsp
);
	import mio_pkg::*;

	// ----------------------------------------------------------------
	// Masks of populated lines
	// ----------------------------------------------------------------
	// Extended lines count only once enabled and only as far as populated
	function automatic logic [IN_W-1:0] in_mask(input logic en);
		logic [IN_W-1:0] m;
		m = '0;
		for (int i = 0; i < IN_W; i++) begin
			m[i] = (i < BASE_IN_N) || (en && (i < BASE_IN_N + EXT_IN_N));
		end
		return m;
	endfunction : in_mask

	function automatic logic [OUT_W-1:0] out_mask(input logic en);
		logic [OUT_W-1:0] m;
		m = '0;
		for (int i = 0; i < OUT_W; i++) begin
			m[i] = (i < BASE_OUT_N) || (en && (i < BASE_OUT_N + EXT_OUT_N));
		end
		return m;
	endfunction : out_mask

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic [IN_W-1:0] in_s1_r;
	logic [IN_W-1:0] in_s2_r;
	logic [HALL_W-1:0] hall_s1_r;
	logic [HALL_W-1:0] hall_s2_r;

	// Reset to the pulled-up level so early reads see idle lines
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			in_s1_r <= IN_IDLE;
			in_s2_r <= IN_IDLE;
			hall_s1_r <= HALL_IDLE;
			hall_s2_r <= HALL_IDLE;
		end else begin
			in_s1_r <= in_pins;
			in_s2_r <= in_s1_r;
			hall_s1_r <= main_hall_pins;
			hall_s2_r <= hall_s1_r;
		end
	end

	// ----------------------------------------------------------------
	// Control, output and response state
	// ----------------------------------------------------------------
	logic ext_in_en_r;
	logic ext_in_en_nxt;
	logic ext_out_en_r;
	logic ext_out_en_nxt;
	logic [OUT_W-1:0] on_r;
	logic [OUT_W-1:0] on_nxt;
	logic brake_r;
	logic brake_nxt;
	logic [HALL_W-1:0] hall_r;
	logic [HALL_W-1:0] hall_nxt;
	mio_rsp_s rsp_r;
	mio_rsp_s rsp_nxt;
	logic [IN_W-1:0] visible;
	logic hall_from_main;

	// Next values of all host-visible state
	always_comb begin
		hall_from_main = opt_setup_code[HALL_SRC_BIT];
		// Unpopulated or disabled lines look like open, pulled-up inputs
		visible = in_s2_r | ~in_mask(ext_in_en_r);
		// A shared line lent to commutation is hidden from software
		if (hall_claim && !hall_from_main) begin
			visible[SHARED_LAST:SHARED_FIRST] = HALL_IDLE;
		end
		// Hall source picked by the setup code bit
		if (!hall_claim) begin
			hall_nxt = HALL_IDLE;
		end else if (hall_from_main) begin
			hall_nxt = hall_s2_r;
		end else begin
			hall_nxt = in_s2_r[SHARED_LAST:SHARED_FIRST];
		end
		ext_in_en_nxt = ext_in_en_r;
		ext_out_en_nxt = ext_out_en_r;
		on_nxt = on_r;
		rsp_nxt = '0;
		unique case (cmd.op)
			MIO_OP_NONE: begin
			end
			MIO_OP_READ_ALL: begin
				rsp_nxt.valid = 1'b1;
				rsp_nxt.word = visible;
			end
			MIO_OP_READ_ONE: begin
				rsp_nxt.valid = 1'b1;
				// Out-of-range index answers as an open line
				rsp_nxt.line_val = (cmd.idx < IDX_W'(IN_W)) ? visible[cmd.idx] : 1'b1;
			end
			MIO_OP_SET_OUT: begin
				on_nxt = cmd.data & out_mask(ext_out_en_r);
			end
			MIO_OP_EXT_SETUP: begin
				ext_in_en_nxt = cmd.data[EXT_IN_EN_BIT];
				ext_out_en_nxt = cmd.data[EXT_OUT_EN_BIT];
				// Disabling extended outputs releases them at once
				on_nxt = on_r & out_mask(cmd.data[EXT_OUT_EN_BIT]);
			end
			default: begin
			end
		endcase
		brake_nxt = brake_engage;
	end

	// Registers; reset leaves every driver off
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ext_in_en_r <= 1'b0;
			ext_out_en_r <= 1'b0;
			on_r <= OUT_RST;
			brake_r <= 1'b0;
			hall_r <= HALL_IDLE;
			rsp_r <= '0;
		end else begin
			ext_in_en_r <= ext_in_en_nxt;
			ext_out_en_r <= ext_out_en_nxt;
			on_r <= on_nxt;
			brake_r <= brake_nxt;
			hall_r <= hall_nxt;
			rsp_r <= rsp_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Pin drive
	// ----------------------------------------------------------------
	// Open collector: a driven line only ever sinks
	// One driver for the whole carrier; the enable alone decides who sinks
	assign out_pins = '{o: OUT_RST, oe: on_r};
	assign brake_o = 1'b0;
	assign brake_oe = brake_r;
	assign hall_sig = hall_r;
	assign rsp = rsp_r;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence s_base_steady;
		$stable(in_pins[SHARED_FIRST-1:0]) [*3];
	endsequence

	sequence s_read_all;
		cmd.op == MIO_OP_READ_ALL;
	endsequence

	a_out_held: assert property ($changed(out_pins.oe) |->
		$past(cmd.op) inside {MIO_OP_SET_OUT, MIO_OP_EXT_SETUP})
		else $error("output enables moved without a command");
	a_out_follow: assert property (cmd.op == MIO_OP_SET_OUT |=>
		out_pins.oe[BASE_OUT_N-1:0] == $past(cmd.data[BASE_OUT_N-1:0]) && out_pins.o == '0)
		else $error("base outputs do not follow set command");
	a_brake_drive: assert property (brake_engage |=> brake_oe && !brake_o)
		else $error("brake not pulled low when engaged");
	a_brake_float: assert property (!brake_engage |=> !brake_oe)
		else $error("brake driven while released");
	a_base_read: assert property (s_base_steady ##0 s_read_all |=>
		rsp.valid && rsp.word[SHARED_FIRST-1:0] == $past(in_pins[SHARED_FIRST-1:0]))
		else $error("steady input not returned after sync delay");
	a_sync_depth: assert property ($past(rst_n, 2) |-> in_s2_r == $past(in_pins, 2))
		else $error("synchroniser depth is not two");
	a_shared_owned: assert property (hall_claim && !hall_from_main && cmd.op == MIO_OP_READ_ALL
		|=> rsp.word[SHARED_LAST:SHARED_FIRST] == HALL_IDLE)
		else $error("hall-owned line visible to software");
	a_hall_main: assert property (hall_claim && hall_from_main |=> hall_sig == $past(hall_s2_r))
		else $error("hall not taken from main connector");
	a_hall_shared: assert property (hall_claim && !hall_from_main |=>
		hall_sig == $past(in_s2_r[SHARED_LAST:SHARED_FIRST]))
		else $error("hall not taken from shared lines");
	a_ext_idle: assert property (!ext_in_en_r && cmd.op == MIO_OP_READ_ALL |=>
		rsp.word[IN_W-1:BASE_IN_N] == '1)
		else $error("disabled extended inputs do not read one");
	a_rsp_pulse: assert property (!(cmd.op inside {MIO_OP_READ_ALL, MIO_OP_READ_ONE}) |=> !rsp.valid)
		else $error("answer without a read");
endmodule : mio_port

// File: tb/mio_field_model.sv
// Field side model: pulled-up switches on the input bus and hall sensors on the main cable
`timescale 1ns/100ps
module mio_field_model (
	// Switch stimulus
	input wire logic [mio_pkg::IN_W-1:0] drive_en,
	input wire logic [mio_pkg::IN_W-1:0] drive_val,
	input wire logic [mio_pkg::HALL_W-1:0] hall_val,
	// Connector pins
	output logic [mio_pkg::IN_W-1:0] in_pins,
	output logic [mio_pkg::HALL_W-1:0] main_hall_pins
);
	// ----------------------------------------------------------------
	// Pin levels
	// ----------------------------------------------------------------
	// A released switch leaves the line to its pull-up resistor
	assign in_pins = drive_val | ~drive_en;
	// Sensors on the main cable drive all the time; the shared lines carry only the switches
	assign main_hall_pins = hall_val;
endmodule : mio_field_model

// File: tb/mio_port_bench.sv
// Self-checking bench of the motion I/O port
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
	$display("unexpected at %0t: %h vs %h", $time, a, b); end end
module mio_port_bench;
	import mio_pkg::*;
	localparam int unsigned EXT_N = 20;
	logic mclk = 1'b0;
	logic rst_n, claim, brake, ext, b3;
	logic [IN_W-1:0] d_en, d_val, pins, nl, e;
	logic [HALL_W-1:0] hall_m, mhall;
	logic [CFG_W-1:0] setup;
	logic [HALL_W-1:0] hall_sig;
	logic [31:0] seed = 32'h0000_0041;
	logic [31:0] d;
	logic [5:0] ix;
	logic brake_o, brake_oe;
	mio_cmd_s cmd;
	mio_rsp_s rsp;
	mio_oc_s out_pins;
	int failures = 0;
	int checks = 0;
	// ----------------------------------------------------------------
	// Clock, partner and design
	// ----------------------------------------------------------------
	always #10 mclk = ~mclk;
	mio_field_model i_field (.drive_en(d_en), .drive_val(d_val), .hall_val(hall_m),
		.in_pins(pins), .main_hall_pins(mhall));
	mio_port #(.EXT_IN_N(EXT_N), .EXT_OUT_N(EXT_N)) i_dut (.mclk(mclk), .rst_n(rst_n),
		.in_pins(pins), .main_hall_pins(mhall), .out_pins(out_pins), .brake_o(brake_o),
		.brake_oe(brake_oe), .opt_setup_code(setup), .hall_claim(claim),
		.brake_engage(brake), .hall_sig(hall_sig), .cmd(cmd), .rsp(rsp));
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// What software should see; unpopulated or disabled lines read high
	function automatic logic [IN_W-1:0] vis(logic [IN_W-1:0] p);
		logic [IN_W-1:0] v;
		v = p;
		for (int i = 16; i < IN_W; i++) if (!ext || i >= 16 + EXT_N) v[i] = 1'b1;
		if (claim && !b3) v[15:4] = 12'hfff;
		return v;
	endfunction : vis
	// Command held from one falling edge to the next
	task go(mio_op_e o, logic [31:0] dd, logic [5:0] i);
		cmd = '{o, dd, i};
		@(negedge mclk);
	endtask : go
	task rdall(logic [IN_W-1:0] x);
		go(MIO_OP_READ_ALL, 32'h0000_0000, 6'h00);
		`CHK(rsp, {1'b1, x, 1'b0})
	endtask : rdall
	task end_of_test();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : end_of_test
	// ----------------------------------------------------------------
	// Watchdog and main sequence
	// ----------------------------------------------------------------
	initial begin
		#20000;
		failures++;
		end_of_test();
	end
	initial begin
		{rst_n, claim, brake, ext, b3, d_en, d_val, hall_m, setup} = '0;
		cmd = '{MIO_OP_NONE, 32'h0000_0000, 6'h00};
		repeat (12) @(negedge mclk);
		`CHK(out_pins.oe, OUT_RST)
		`CHK({brake_oe, hall_sig}, {1'b0, HALL_IDLE})
		rst_n = 1'b1;
		go(MIO_OP_NONE, 32'h0000_0000, 6'h00);
		rdall(vis(IN_IDLE));
		`CHK(out_pins, {OUT_RST, OUT_RST})
		for (int k = 0; k < 8; k++) begin
			{b3, claim, ext} = 3'(k);
			setup = {4'h0, b3, 3'h0};
			go(MIO_OP_EXT_SETUP, {30'h0, ext, ext}, 6'h00);
			go(MIO_OP_NONE, 32'h0000_0000, 6'h00);
			e = vis(pins);
			d_en = IN_W'({rnd(), rnd()});
			d_val = IN_W'({rnd(), rnd()});
			hall_m = HALL_W'(rnd());
			nl = d_val | ~d_en;
			// Two synchroniser stages hide the change for two reads
			rdall(e);
			rdall(e);
			rdall(vis(nl));
			`CHK(hall_sig, claim ? (b3 ? hall_m : nl[15:4]) : HALL_IDLE)
			ix = 6'(rnd() % 44);
			e = vis(nl);
			go(MIO_OP_READ_ONE, 32'h0000_0000, ix);
			`CHK(rsp, {1'b1, 40'h0, (ix >= 40) ? 1'b1 : e[ix]})
			d = rnd();
			go(MIO_OP_SET_OUT, d, 6'h00);
			`CHK(out_pins, {32'h0, ext ? d & 32'h0fff_ffff : {24'h0, d[7:0]}})
			brake = ext;
			go(MIO_OP_NONE, 32'h0000_0000, 6'h00);
			`CHK({brake_o, brake_oe}, {1'b0, ext})
		end
		// Reset in mid-run releases every driven line at once
		rst_n = 1'b0;
		#1;
		`CHK(out_pins.oe, OUT_RST)
		`CHK(brake_oe, 1'b0)
		end_of_test();
	end
endmodule : mio_port_bench
